// ==== hdl/bmx_lane_mux_8to8.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Transmit takes eight client lanes to eight lower lanes and receive does the mirror move.
// - The aggregate is handled as thirty-two interleaved coding sublayer lanes each way.
// - The four sublanes of one input lane always leave together on one output lane.
// - Those four sublanes may be reordered within their shared output lane.
// - The general scheme uses 8 or 16 sublanes of 26.5625 Gb/s each.
// - On an input lane the next bit of a sublane follows every sublane-count bit positions.
// - Input sublanes are accepted in whatever interleave order they arrive.
// - On an output lane the next bit of a sublane is placed every sublane-count positions.
// - The chosen output interleave never changes while input streams stay valid.
// - PAM4 symbols are split into bit pairs on input and rebuilt from pairs on output.
// - In symbol mode one symbol carries two bits, otherwise each position carries one bit.
// - Every sublane from any input slot lands in some output slot and none is dropped.
// - Beyond the grouping constraint the lane mapping is free because the far end reorders.
// - One parallel stream per lane is driven continuously towards the medium side; the block drives zeros with valid low before lock and in idle cycles.
// - Output groupings that lower transition density should be avoided.
module bmx_lane_mux_8to8
   import bmx_pkg::*;
#(
   parameter int LANE_W = 32
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [BMX_LANES-1:0][LANE_W-1:0] tx_client_data,
   input wire logic tx_client_valid,
   output logic [BMX_LANES-1:0][LANE_W-1:0] tx_line_data,
   output logic tx_line_valid,
   input wire logic [BMX_LANES-1:0][LANE_W-1:0] rx_line_data,
   input wire logic rx_line_valid,
   output logic [BMX_LANES-1:0][LANE_W-1:0] rx_client_data,
   output logic rx_client_valid,
   input wire bmx_lane_map_t strap_tx_map,
   input wire bmx_lane_map_t strap_rx_map,
   input wire bmx_slot_order_t strap_slot_order,
   input wire logic strap_pam4,
   output logic map_locked,
   output logic map_fault
);

   typedef logic [BMX_LANES-1:0][LANE_W-1:0] bmx_bus_t;

   // All state of the block, including the strap synchronisers.
   typedef struct packed {
      bmx_lane_map_t tx_map_s1;
      bmx_lane_map_t tx_map_s2;
      bmx_lane_map_t rx_map_s1;
      bmx_lane_map_t rx_map_s2;
      bmx_slot_order_t order_s1;
      bmx_slot_order_t order_s2;
      logic pam4_s1;
      logic pam4_s2;
      bmx_state_t st;
      logic [1:0] cnt;
      bmx_lane_map_t tx_map;
      bmx_lane_map_t rx_map;
      bmx_slot_order_t order;
      logic pam4;
      logic locked;
      logic fault;
      bmx_bus_t tx_data;
      logic tx_valid;
      bmx_bus_t rx_data;
      logic rx_valid;
   } bmx_regs_t;

   bmx_regs_t r;
   bmx_regs_t nxt;
   bmx_bus_t tx_perm;
   bmx_bus_t rx_perm;

   // In symbol mode the most significant bit of each pair is the earlier bit in time.
   // Swapping the pair puts the bits in time order so slots are counted in bits.
   function automatic logic [LANE_W-1:0] pair_conv(input logic [LANE_W-1:0] d,
                                                   input logic pam4);
      logic [LANE_W-1:0] o;
      o = d;
      if (pam4) begin
         for (int i = 0; i < LANE_W; i += 2) begin
            o[i] = d[i+1];
            o[i+1] = d[i];
         end
      end
      return o;
   endfunction : pair_conv

   // Each output lane takes one whole input lane, then reorders its four slots.
   // Keeping the four sublanes together means no new mix of sublanes is formed,
   // so each sublane is carried over whole; the lane's transition density stays unchanged only with the straight slot order.
   for (genvar j = 0; j < BMX_LANES; j++) begin : g_lane
      bmx_lane_if #(.W(LANE_W)) tx_if();
      bmx_lane_if #(.W(LANE_W)) rx_if();

      assign tx_if.din = pair_conv(tx_client_data[r.tx_map[j]], r.pam4);
      assign tx_if.order = r.order;
      assign tx_perm[j] = pair_conv(tx_if.dout, r.pam4);
      assign rx_if.din = pair_conv(rx_line_data[r.rx_map[j]], r.pam4);
      assign rx_if.order = r.order;
      assign rx_perm[j] = pair_conv(rx_if.dout, r.pam4);

      bmx_slot_permuter #(.W(LANE_W)) u_tx_perm (
         .p(tx_if)
      );

      bmx_slot_permuter #(.W(LANE_W)) u_rx_perm (
         .p(rx_if)
      );
   end

   // Next-state logic: strap synchronisers, mapping capture and the data stage.
   always_comb begin
      nxt = r;
      // Straps are asynchronous pins; only the second stage feeds the capture,
      // so a strap edge near reset release cannot put metastable bits in the mapping.
      nxt.tx_map_s1 = strap_tx_map;
      nxt.rx_map_s1 = strap_rx_map;
      nxt.order_s1 = strap_slot_order;
      nxt.pam4_s1 = strap_pam4;
      nxt.tx_map_s2 = r.tx_map_s1;
      nxt.rx_map_s2 = r.rx_map_s1;
      nxt.order_s2 = r.order_s1;
      nxt.pam4_s2 = r.pam4_s1;
      unique case (r.st)
         BMX_ST_WAIT: begin
            if (r.cnt == BMX_SYNC_CNT) begin
               // A strapped map that would drop a lane is replaced by the identity.
               nxt.tx_map = bmx_is_perm8(r.tx_map_s2) ? r.tx_map_s2 : BMX_ID_MAP;
               nxt.rx_map = bmx_is_perm8(r.rx_map_s2) ? r.rx_map_s2 : BMX_ID_MAP;
               nxt.order = bmx_is_perm4(r.order_s2) ? r.order_s2 : BMX_ID_ORDER;
               // One flag covers all three checks; a user cannot tell from it which
               // item fell back to the straight-through order.
               nxt.fault = !(bmx_is_perm8(r.tx_map_s2) && bmx_is_perm8(r.rx_map_s2)
                             && bmx_is_perm4(r.order_s2));
               nxt.pam4 = r.pam4_s2;
               nxt.locked = 1'b1;
               nxt.st = BMX_ST_RUN;
            end else begin
               nxt.cnt = r.cnt + BMX_CNT_STEP;
            end
         end
         BMX_ST_RUN: begin
            // Mapping is frozen here; only reset returns to the wait state.
            nxt.st = BMX_ST_RUN;
         end
      endcase
      // One-cycle data stage for each direction; idle lanes drive zeros.
      nxt.tx_valid = r.locked && tx_client_valid;
      nxt.tx_data = (r.locked && tx_client_valid) ? tx_perm : '0;
      nxt.rx_valid = r.locked && rx_line_valid;
      nxt.rx_data = (r.locked && rx_line_valid) ? rx_perm : '0;
   end

   // State register with synchronous reset to the all-zero state.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   // Every output comes straight from the state register.
   assign tx_line_data = r.tx_data;
   assign tx_line_valid = r.tx_valid;
   assign rx_client_data = r.rx_data;
   assign rx_client_valid = r.rx_valid;
   assign map_locked = r.locked;
   assign map_fault = r.fault;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // The data checks below look one cycle past the data stage and compare against the
   // words the block took, so they hold for any strapped mapping, not only identity.
   // Single bit and single lane spot checks keep them cheap; the bench compares whole words.

   // Lock comes exactly after the strap synchroniser has filled.
   sequence s_wait_lock;
      !r.locked [*3] ##1 r.locked;
   endsequence

   sequence s_locked_tx;
      r.locked && tx_client_valid;
   endsequence

   sequence s_locked_rx;
      r.locked && rx_line_valid;
   endsequence

   a_lock_timing:
   assert property ($fell(reset) |-> s_wait_lock)
      else $error("mapping lock not reached three cycles after reset release");

   a_map_static:
   assert property (r.locked |=> $stable(r.tx_map) && $stable(r.rx_map)
                    && $stable(r.order) && $stable(r.pam4))
      else $error("mapping changed while running");

   a_map_perm:
   assert property (r.locked |-> bmx_is_perm8(r.tx_map) && bmx_is_perm8(r.rx_map)
                    && bmx_is_perm4(r.order))
      else $error("active mapping drops a lane or slot");

   a_tx_valid_lat:
   assert property (s_locked_tx |=> tx_line_valid ##0 r.locked)
      else $error("transmit word not delivered one cycle later");

   a_rx_valid_lat:
   assert property (r.locked && rx_line_valid |=> rx_client_valid)
      else $error("receive word not delivered one cycle later");

   a_tx_group:
   assert property (s_locked_tx |=> $countones(tx_line_data[0])
                    == $countones($past(tx_client_data[r.tx_map[0]])))
      else $error("output lane does not carry one whole input lane");

   a_rx_group:
   assert property (r.locked && rx_line_valid |=> $countones(rx_client_data[1])
                    == $countones($past(rx_line_data[r.rx_map[1]])))
      else $error("receive lane does not carry one whole input lane");

   // Plain bit mode: the second group of a lane follows the shared slot order.
   a_slot_place:
   assert property (s_locked_tx and !r.pam4 |=> tx_line_data[0][BMX_SLOTS]
                    == $past(tx_client_data[r.tx_map[0]][BMX_SLOTS+r.order[0]]))
      else $error("slot placement breaks the four bit period");

   // With the straight order the two pair swaps cancel and the word passes whole.
   a_pam4_pairs:
   assert property (s_locked_tx and r.pam4 and r.order == BMX_ID_ORDER
                    |=> tx_line_data[2] == $past(tx_client_data[r.tx_map[2]]))
      else $error("symbol pairs not rebuilt on output");

   a_idle_zero:
   assert property (!r.locked |=> !tx_line_valid && !rx_client_valid)
      else $error("valid raised before mapping lock");

   // The lock flag gates both data paths, so losing it would silently drop traffic.
   a_lock_hold:
   assert property (r.locked |=> r.locked)
      else $error("mapping lock lost without reset");

   a_sync_count:
   assert property (r.cnt <= BMX_SYNC_CNT)
      else $error("strap settle counter ran past its end");

   // A fault is only known once the straps are captured, and then it cannot move.
   a_fault_early:
   assert property (!r.locked |-> !r.fault)
      else $error("fault flagged before the mapping was captured");

   a_fault_hold:
   assert property (r.locked |=> $stable(r.fault))
      else $error("fault flag changed while running");

   // Idle cycles must not leak stale words towards either side.
   a_tx_idle_data:
   assert property (!(r.locked && tx_client_valid) |=> tx_line_data == '0)
      else $error("transmit lanes not zero in an idle cycle");

   a_rx_drop:
   assert property (!(r.locked && rx_line_valid)
                    |=> !rx_client_valid && rx_client_data == '0)
      else $error("receive word delivered without a valid input word");

   // Two consecutive bits of one sublane must sit exactly one group apart.
   a_sub_period:
   assert property (s_locked_tx and !r.pam4 |=> tx_line_data[4][0]
                    == $past(tx_client_data[r.tx_map[4]][r.order[0]])
                    && tx_line_data[4][BMX_SLOTS]
                    == $past(tx_client_data[r.tx_map[4]][BMX_SLOTS+r.order[0]]))
      else $error("sublane bits not one group apart on the output lane");

   a_rx_sub_period:
   assert property (s_locked_rx and !r.pam4 |=> rx_client_data[6][1]
                    == $past(rx_line_data[r.rx_map[6]][r.order[1]])
                    && rx_client_data[6][BMX_SLOTS+1]
                    == $past(rx_line_data[r.rx_map[6]][BMX_SLOTS+r.order[1]]))
      else $error("receive sublane bits not one group apart");

   // Receive placement uses the same slot order as transmit.
   a_rx_slot_place:
   assert property (s_locked_rx and !r.pam4 |=> rx_client_data[3][2*BMX_SLOTS+1]
                    == $past(rx_line_data[r.rx_map[3]][2*BMX_SLOTS+r.order[1]]))
      else $error("receive slot placement breaks the four bit period");

   // In symbol mode slots are counted in time order, so each raw index is pair swapped.
   a_pam4_slot:
   assert property (s_locked_tx and r.pam4 |=> tx_line_data[1][1]
                    == $past(tx_client_data[r.tx_map[1]][r.order[0]^2'h1]))
      else $error("symbol mode slot not taken from the time ordered bit");

   a_rx_pam4_slot:
   assert property (s_locked_rx and r.pam4 |=> rx_client_data[7][3]
                    == $past(rx_line_data[r.rx_map[7]][r.order[2]^2'h1]))
      else $error("receive symbol slot not taken from the time ordered bit");

   // Receive side of the whole-word symbol check.
   a_rx_pam4_pairs:
   assert property (s_locked_rx and r.pam4 and r.order == BMX_ID_ORDER
                    |=> rx_client_data[5] == $past(rx_line_data[r.rx_map[5]]))
      else $error("receive symbol pairs not rebuilt on output");

endmodule : bmx_lane_mux_8to8

// ==== hdl/bmx_pkg.sv ====
package bmx_pkg;

   // Lane geometry of the eight-to-eight variant.
   localparam int BMX_LANES = 8;
   localparam int BMX_SLOTS = 4;
   localparam int BMX_SUBLANES = BMX_LANES * BMX_SLOTS;
   localparam int BMX_SEL_W = 3;
   localparam int BMX_ORD_W = 2;

   // Sublane counts and rates of the general scheme, kept for reference by users.
   localparam int BMX_SUBLANES_LOW = 8;
   localparam int BMX_SUBLANES_HIGH = 16;
   localparam real BMX_SUBLANE_GBPS = 26.5625;
   localparam real BMX_SYMBOL_GBD = 53.125;

   // Strap synchroniser depth; capture happens on the edge after the last stage fills.
   localparam int BMX_SYNC_STAGES = 2;
   localparam logic [1:0] BMX_SYNC_CNT = 2'(BMX_SYNC_STAGES);
   localparam logic [1:0] BMX_CNT_STEP = 2'h1;

   typedef logic [BMX_SEL_W-1:0] bmx_lane_sel_t;
   typedef bmx_lane_sel_t [BMX_LANES-1:0] bmx_lane_map_t;
   typedef logic [BMX_ORD_W-1:0] bmx_slot_sel_t;
   typedef bmx_slot_sel_t [BMX_SLOTS-1:0] bmx_slot_order_t;

   typedef enum logic [0:0] {
      BMX_ST_WAIT = 1'b0,
      BMX_ST_RUN = 1'b1
   } bmx_state_t;

   // Straight-through mappings used when a strapped mapping would drop a lane.
   localparam bmx_lane_map_t BMX_ID_MAP = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   localparam bmx_slot_order_t BMX_ID_ORDER = {2'h3, 2'h2, 2'h1, 2'h0};

   // True when every input lane is used exactly once.
   function automatic logic bmx_is_perm8(input bmx_lane_map_t m);
      logic [BMX_LANES-1:0] seen;
      seen = '0;
      for (int i = 0; i < BMX_LANES; i++) begin
         seen[m[i]] = 1'b1;
      end
      return &seen;
   endfunction : bmx_is_perm8

   // True when every slot is used exactly once.
   function automatic logic bmx_is_perm4(input bmx_slot_order_t o);
      logic [BMX_SLOTS-1:0] seen;
      seen = '0;
      for (int i = 0; i < BMX_SLOTS; i++) begin
         seen[o[i]] = 1'b1;
      end
      return &seen;
   endfunction : bmx_is_perm4

endpackage : bmx_pkg

// ==== hdl/bmx_lane_if.sv ====
`timescale 1ns/1ps
// Carries one lane word and the slot order between the mux and a slot permuter.
interface bmx_lane_if
   import bmx_pkg::*;
#(
   parameter int W = 32
);
   logic [W-1:0] din;
   logic [W-1:0] dout;
   bmx_slot_order_t order;

   modport perm(input din, input order, output dout);
   modport user(output din, output order, input dout);
endinterface : bmx_lane_if

// ==== hdl/bmx_slot_permuter.sv ====
`timescale 1ns/1ps
// Reorders the four sublane slots inside every group of four bits of one lane word.
module bmx_slot_permuter
   import bmx_pkg::*;
#(
   parameter int W = 32
) (
   bmx_lane_if.perm p
);

   // Slot s of every group takes input slot order[s]; the group period stays four bits.
   always_comb begin
      p.dout = '0;
      for (int k = 0; k < W / BMX_SLOTS; k++) begin
         for (int s = 0; s < BMX_SLOTS; s++) begin
            p.dout[k*BMX_SLOTS+s] = p.din[k*BMX_SLOTS+p.order[s]];
         end
      end
   end

endmodule : bmx_slot_permuter

// ==== test/bmx_far_end.sv ====
`timescale 1ns/1ps
// Medium-side partner that streams random lane words into the receive path.
module bmx_far_end
   import bmx_pkg::*;
(
   input wire logic core_clk,
   input wire logic en,
   output logic [BMX_LANES-1:0][31:0] line_data,
   output logic line_valid
);
   initial begin
      line_data = '0;
      line_valid = 1'b0;
   end
   // A fresh word every cycle, so stale data is never mistaken for a match.
   always @(negedge core_clk) begin
      line_valid <= en && ($urandom % 4 != 0);
      for (int i = 0; i < BMX_LANES; i++) begin
         line_data[i] <= $urandom;
      end
   end
endmodule : bmx_far_end

// ==== test/lane_bit_multiplexer_8to8_bench.sv ====
`timescale 1ns/1ps
// Self-checking bench: random words both ways, checked against a reference mapping.
module lane_bit_multiplexer_8to8_bench
   import bmx_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset;
   logic far_en;
   logic [7:0][31:0] tx_client_data, tx_line_data, rx_line_data, rx_client_data;
   logic tx_client_valid, tx_line_valid, rx_line_valid, rx_client_valid;
   logic map_locked, map_fault, pm;
   bmx_lane_map_t strap_tx_map, strap_rx_map, em_t, em_r;
   bmx_slot_order_t strap_slot_order, eo;
   int fail_count = 0;
   int comparisons = 0;

   always #2 core_clk = ~core_clk;

   bmx_lane_mux_8to8 #(.LANE_W(32)) DUT (.core_clk(core_clk), .reset(reset),
      .tx_client_data(tx_client_data), .tx_client_valid(tx_client_valid),
      .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid),
      .rx_line_data(rx_line_data), .rx_line_valid(rx_line_valid),
      .rx_client_data(rx_client_data), .rx_client_valid(rx_client_valid),
      .strap_tx_map(strap_tx_map), .strap_rx_map(strap_rx_map),
      .strap_slot_order(strap_slot_order), .strap_pam4(pm),
      .map_locked(map_locked), .map_fault(map_fault));

   bmx_far_end far (.core_clk(core_clk), .en(far_en), .line_data(rx_line_data),
      .line_valid(rx_line_valid));

   // Swaps the two bits of every symbol.
   function automatic logic [31:0] pswap(input logic [31:0] w);
      for (int k = 0; k < 32; k++) begin
         pswap[k] = w[k ^ 1];
      end
   endfunction : pswap

   // Reference slot reorder inside each group of four, with symbol split and rebuild.
   function automatic logic [31:0] exp_word(input logic [31:0] w);
      logic [31:0] a;
      logic [31:0] r;
      a = pm ? pswap(w) : w;
      for (int k = 0; k < 32; k++) begin
         r[k] = a[(k & ~3) + int'(eo[k % 4])];
      end
      return pm ? pswap(r) : r;
   endfunction : exp_word

   // Random shuffle of n entries, or the straight-through order when n is negative.
   function automatic bmx_lane_map_t shuf(input int n);
      bmx_lane_map_t m;
      bmx_lane_sel_t t;
      int j;
      for (int i = 0; i < 8; i++) begin
         m[i] = i[2:0];
      end
      for (int i = n - 1; i > 0; i--) begin
         j = $urandom % (i + 1);
         t = m[i];
         m[i] = m[j];
         m[j] = t;
      end
      return m;
   endfunction : shuf

   // Slot order from a shuffle; a plain cast would mix the three bit map fields.
   function automatic bmx_slot_order_t shuf_ord(input int n);
      bmx_lane_map_t m;
      bmx_slot_order_t o;
      m = shuf(n);
      for (int i = 0; i < 4; i++) begin
         o[i] = m[i][1:0];
      end
      return o;
   endfunction : shuf_ord

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Straps are set under reset; valid is held high so early words must vanish.
   task automatic restart(input logic f);
      int w;
      @(negedge core_clk);
      reset <= 1'b1;
      far_en <= 1'b0;
      tx_client_valid <= 1'b1;
      repeat (8) @(negedge core_clk);
      reset <= 1'b0;
      w = 0;
      while (map_locked !== 1'b1 && w < 10) begin
         @(negedge core_clk);
         chk(tx_line_valid === 1'b0, "word before lock");
         w++;
      end
      chk(map_locked === 1'b1 && w == 3, "lock timing");
      chk(map_fault === f, "fault flag");
   endtask : restart

   // Each cycle checks outputs against the inputs the last edge took, then drives anew.
   task automatic run(input int n);
      logic [31:0] et;
      logic [31:0] er;
      for (int c = 0; c < n; c++) begin
         far_en <= 1'b1;
         tx_client_valid <= ($urandom % 4 != 0);
         for (int i = 0; i < 8; i++) begin
            tx_client_data[i] <= (c % 16 == 0) ? {8{4'ha}} : $urandom;
         end
         @(negedge core_clk);
         for (int j = 0; j < 8; j++) begin
            et = tx_client_valid ? exp_word(tx_client_data[em_t[j]]) : 32'h0;
            er = rx_line_valid ? exp_word(rx_line_data[em_r[j]]) : 32'h0;
            chk(tx_line_data[j] === et, "tx word");
            chk(rx_client_data[j] === er, "rx word");
         end
         chk(tx_line_valid === tx_client_valid, "tx valid");
         chk(rx_client_valid === rx_line_valid, "rx valid");
      end
   endtask : run

   initial begin
      void'($urandom(32'h3e4c));
      reset = 1'b1;
      far_en = 1'b0;
      tx_client_data = '0;
      tx_client_valid = 1'b0;
      pm = 1'b0;
      strap_tx_map = '0;
      strap_rx_map = '0;
      strap_slot_order = '0;
      // Both symbol modes with random lane and slot permutations.
      for (int p = 0; p < 2; p++) begin
         em_t = shuf(8);
         em_r = shuf(8);
         eo = shuf_ord(4);
         strap_tx_map = em_t;
         strap_rx_map = em_r;
         strap_slot_order = eo;
         pm = p[0];
         restart(1'b0);
         run(200);
         // Strap moves after lock must not disturb the chosen mapping.
         strap_tx_map = shuf(8);
         strap_slot_order = shuf_ord(4);
         run(50);
      end
      // Maps that drop lanes fall back to straight through; symbol mode is on so the
      // straight order also exercises whole-word symbol rebuild.
      strap_tx_map = '0;
      strap_slot_order = '0;
      em_t = shuf(-1);
      eo = shuf_ord(-1);
      pm = 1'b1;
      restart(1'b1);
      run(100);
      report_and_stop();
   end

   // Cuts a hang short well past the roughly 640 cycles the tests need.
   initial begin
      #40000;
      fail_count++;
      report_and_stop();
   end
endmodule : lane_bit_multiplexer_8to8_bench
